//--- vendor_bank_defines.vh
// Register offsets, field positions and reset values of the vendor bank.
// Included by the top design file of the bank only; definitions only.
`ifndef VENDOR_BANK_DEFINES_VH
`define VENDOR_BANK_DEFINES_VH

`define OFS_POWER_CONTROL 8'h3d
`define OFS_POWER_CONTROL_SET 8'h3e
`define OFS_POWER_CONTROL_CLR 8'h3f
`define OFS_EYE_TUNING 8'h80
`define OFS_EYE_TUNING_SET 8'h81
`define OFS_EYE_TUNING_CLR 8'h82
`define OFS_DETECTOR_STATUS 8'h83
`define OFS_DETECTOR_LATCH 8'h84
`define OFS_PIN_REGULATOR 8'h85
`define OFS_PIN_REGULATOR_SET 8'h86
`define OFS_PIN_REGULATOR_CLR 8'h87

`define RST_POWER_CONTROL 8'h00
`define RST_EYE_TUNING 8'h41
`define RST_PIN_REGULATOR 8'h03

// Power control fields
`define PC_STRESS_EN 0
`define PC_SPARE_LOW 1
`define PC_BSESS_RISE_EN 2
`define PC_BSESS_FALL_EN 3
`define PC_ID_RESISTOR_EVENT_ENABLE 4
`define PC_ID_OPEN_EN 5
`define PC_SUPPLY_EN 6

// Eye tuning fields
`define EYE_BOOST_BIT 0
`define EYE_DRIVE_MSB 3
`define EYE_IMPED_LSB 4
`define EYE_IMPED_MSB 5
`define EYE_POLARITY 6

// Pin and regulator fields
`define PR_VSEL_MSB 2
`define PR_ID_GROUND 3
`define PR_DRIVER_MODE 4
`define PR_DRAIN_SOURCE 5
`define PR_SOF_EN 6

// Detector bit positions in status and latch
`define DET_BSESS 0
`define DET_ID_RES_A 1
`define DET_ID_RES_C 3
`define DET_ID_OPEN 4
`define DET_STRESS 5
`define DET_SUPPLY 6
`define DET_WIDTH 7

`endif

//--- alias_reg8.v
// One 8-bit control register with base, set-alias and clear-alias access.
// Assumes write strobes are one-cycle pulses from the register decoder.
`timescale 1ns/1ns
module alias_reg8 #(
	parameter [7:0] RESET_VALUE = 8'h00
) (
	input wire clk,
	input wire rst_n,
	input wire wr_base,
	input wire wr_set,
	input wire wr_clr,
	input wire [7:0] wdata,
	output reg [7:0] value_ff
);
	reg [7:0] nxt_value;

	always @* begin
		nxt_value = value_ff;
		if (wr_base)
			nxt_value = wdata;
		else if (wr_set)
			nxt_value = value_ff | wdata; // [R1]
		else if (wr_clr)
			nxt_value = value_ff & ~wdata; // [R2]
	end

	always @(posedge clk) begin
		if (!rst_n)
			value_ff <= RESET_VALUE;
		else
			value_ff <= nxt_value;
	end
endmodule

//--- detector_sync.v
// Three-flop synchroniser with agreement filter for one detector input.
// Assumes the detector output is asynchronous to the ULPI clock.
`timescale 1ns/1ns
module detector_sync (
	input wire clk,
	input wire rst_n,
	input wire async_in,
	output reg level_ff,
	output reg rise_ff,
	output reg fall_ff
);
	reg meta_ff;
	reg s2_ff;
	reg s3_ff;

	always @(posedge clk) begin
		if (!rst_n) begin
			meta_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			level_ff <= 1'b0;
			rise_ff <= 1'b0;
			fall_ff <= 1'b0;
		end else begin
			meta_ff <= async_in;
			s2_ff <= meta_ff;
			s3_ff <= s2_ff;
			rise_ff <= 1'b0;
			fall_ff <= 1'b0;
			// Change counts only when second and third stages agree
			if (s2_ff == s3_ff && s3_ff != level_ff) begin
				level_ff <= s3_ff;
				rise_ff <= s3_ff;
				fall_ff <= ~s3_ff;
			end
		end
	end
endmodule

//--- ulpi_vendor_bank.v
// Vendor register bank of a ULPI transceiver, on the ULPI clock.
// Assumes the ULPI register engine gives one-cycle read and write strobes
// with an 8-bit address, and takes RX command requests as pulses.
//
// Overview of operation
// [R1] Set alias writes OR ones into register
// [R2] Clear alias writes clear bits written one
// [R3] Stress enable sends RX command both edges
// [R4] Link never writes one to spare bit
// [R5] Status register returns live detector values
// [R6] Latch bit sets on unmasked detector change
// [R7] Latch clears on read and low power
// [R8] Latch clears on serial mode entry
// [R9] Read-cycle event reported, latch not set
// [R10] B-session edge enables send alt-int command
// [R11] ID and supply enables send both edges
// [R12] SOF enable gates device-mode SOF to pin
// [R13] Link keeps SOF enable low normally
// [R14] Driver mode selects push-pull or open
// [R15] Drain/source select: 0 source, 1 drain
// [R16] ID ground drive pulls ID pin low
// [R17] Regulator level select, reset code 011
// [R18] Drive field bit 0 enables AC boost
// [R19] Alias reads return underlying register
`timescale 1ns/1ns
`include "vendor_bank_defines.vh"
module ulpi_vendor_bank (
	input wire CLK,
	input wire RST_N,
	input wire REG_WR,
	input wire REG_RD,
	input wire [7:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	output reg [7:0] REG_RDATA,
	output reg REG_RVALID,
	input wire LOW_POWER_ENTER,
	input wire SERIAL_MODE_ENTER,
	input wire DEVICE_MODE,
	input wire HS_SOF_SEEN,
	input wire B_SESSION_DETECTOR_OUT,
	input wire ID_RESISTOR_A_DETECTOR,
	input wire ID_RESISTOR_B_DETECTOR,
	input wire ID_RESISTOR_C_DETECTOR,
	input wire ID_OPEN_DETECTOR,
	input wire STRESS_DETECTOR_OUT,
	input wire SUPPLY_MONITOR_OUT,
	output reg RX_EVENT,
	output reg RX_ALT_INT,
	output reg CHARGE_PUMP_ENABLE_PIN_O,
	output reg CHARGE_PUMP_ENABLE_PIN_OE,
	output reg ID_GROUND_DRIVE,
	output reg [2:0] USB_REGULATOR_LEVEL_SELECT,
	output reg [3:0] HS_DRIVE_STRENGTH,
	output reg AC_BOOST_ENABLE,
	output reg [1:0] HS_OUTPUT_IMPEDANCE,
	output reg LINE_POLARITY_CONTROL,
	output reg SOF_PULSE_ENABLE
);
	wire [7:0] power_ctrl;
	wire [7:0] eye_ctrl;
	wire [7:0] pin_ctrl;
	wire [`DET_WIDTH-1:0] det_raw;
	wire [`DET_WIDTH-1:0] det_level;
	wire [`DET_WIDTH-1:0] det_rise;
	wire [`DET_WIDTH-1:0] det_fall;
	reg [`DET_WIDTH-1:0] latch_ff;
	reg [`DET_WIDTH-1:0] nxt_latch;
	reg [`DET_WIDTH-1:0] unmasked;
	reg [7:0] rd_mux;
	reg pump_level;
	wire wr_pc;
	wire wr_pc_set;
	wire wr_pc_clr;
	wire wr_eye;
	wire wr_eye_set;
	wire wr_eye_clr;
	wire wr_pr;
	wire wr_pr_set;
	wire wr_pr_clr;
	wire rd_latch;
	wire [7:0] pc_wdata;

	assign wr_pc = REG_WR && REG_ADDR == `OFS_POWER_CONTROL;
	assign wr_pc_set = REG_WR && REG_ADDR == `OFS_POWER_CONTROL_SET;
	assign wr_pc_clr = REG_WR && REG_ADDR == `OFS_POWER_CONTROL_CLR;
	assign wr_eye = REG_WR && REG_ADDR == `OFS_EYE_TUNING;
	assign wr_eye_set = REG_WR && REG_ADDR == `OFS_EYE_TUNING_SET;
	assign wr_eye_clr = REG_WR && REG_ADDR == `OFS_EYE_TUNING_CLR;
	assign wr_pr = REG_WR && REG_ADDR == `OFS_PIN_REGULATOR;
	assign wr_pr_set = REG_WR && REG_ADDR == `OFS_PIN_REGULATOR_SET;
	assign wr_pr_clr = REG_WR && REG_ADDR == `OFS_PIN_REGULATOR_CLR;
	assign rd_latch = REG_RD && REG_ADDR == `OFS_DETECTOR_LATCH;

	// Spare bit stored as written; the link keeps it at zero
	assign pc_wdata = REG_WDATA; // [R4]

	alias_reg8 #(
		.RESET_VALUE(`RST_POWER_CONTROL)
	) u_power_ctrl (
		.clk(CLK),
		.rst_n(RST_N),
		.wr_base(wr_pc),
		.wr_set(wr_pc_set),
		.wr_clr(wr_pc_clr),
		.wdata(pc_wdata),
		.value_ff(power_ctrl)
	);

	alias_reg8 #(
		.RESET_VALUE(`RST_EYE_TUNING)
	) u_eye_ctrl (
		.clk(CLK),
		.rst_n(RST_N),
		.wr_base(wr_eye),
		.wr_set(wr_eye_set),
		.wr_clr(wr_eye_clr),
		.wdata(REG_WDATA),
		.value_ff(eye_ctrl)
	);

	alias_reg8 #(
		.RESET_VALUE(`RST_PIN_REGULATOR)
	) u_pin_ctrl (
		.clk(CLK),
		.rst_n(RST_N),
		.wr_base(wr_pr),
		.wr_set(wr_pr_set),
		.wr_clr(wr_pr_clr),
		.wdata(REG_WDATA),
		.value_ff(pin_ctrl)
	);

	assign det_raw = {SUPPLY_MONITOR_OUT, STRESS_DETECTOR_OUT,
		ID_OPEN_DETECTOR, ID_RESISTOR_C_DETECTOR, ID_RESISTOR_B_DETECTOR,
		ID_RESISTOR_A_DETECTOR, B_SESSION_DETECTOR_OUT};

	genvar gi;
	generate
		for (gi = 0; gi < `DET_WIDTH; gi = gi + 1) begin : g_sync
			detector_sync u_sync (
				.clk(CLK),
				.rst_n(RST_N),
				.async_in(det_raw[gi]),
				.level_ff(det_level[gi]),
				.rise_ff(det_rise[gi]),
				.fall_ff(det_fall[gi])
			);
		end
	endgenerate

	// Per-detector change gated by its enable
	always @* begin
		unmasked = {`DET_WIDTH{1'b0}};
		unmasked[`DET_BSESS] =
			(det_rise[`DET_BSESS] & power_ctrl[`PC_BSESS_RISE_EN]) |
			(det_fall[`DET_BSESS] & power_ctrl[`PC_BSESS_FALL_EN]); // [R10]
		unmasked[`DET_ID_RES_C:`DET_ID_RES_A] =
			(det_rise[`DET_ID_RES_C:`DET_ID_RES_A] |
			det_fall[`DET_ID_RES_C:`DET_ID_RES_A]) &
			{3{power_ctrl[`PC_ID_RESISTOR_EVENT_ENABLE]}}; // [R11]
		unmasked[`DET_ID_OPEN] = (det_rise[`DET_ID_OPEN] |
			det_fall[`DET_ID_OPEN]) & power_ctrl[`PC_ID_OPEN_EN]; // [R11]
		unmasked[`DET_STRESS] = (det_rise[`DET_STRESS] |
			det_fall[`DET_STRESS]) & power_ctrl[`PC_STRESS_EN]; // [R3]
		unmasked[`DET_SUPPLY] = (det_rise[`DET_SUPPLY] |
			det_fall[`DET_SUPPLY]) & power_ctrl[`PC_SUPPLY_EN]; // [R11]
	end

	always @* begin
		nxt_latch = latch_ff | unmasked; // [R6]
		// Mode entry drops old bits; a same-cycle event still lands
		if (LOW_POWER_ENTER || SERIAL_MODE_ENTER)
			nxt_latch = unmasked; // [R7] [R8]
		if (rd_latch)
			nxt_latch = {`DET_WIDTH{1'b0}}; // [R7] [R9]
	end

	always @* begin
		case (REG_ADDR)
			`OFS_POWER_CONTROL,
			`OFS_POWER_CONTROL_SET,
			`OFS_POWER_CONTROL_CLR: rd_mux = power_ctrl; // [R19]
			`OFS_EYE_TUNING,
			`OFS_EYE_TUNING_SET,
			`OFS_EYE_TUNING_CLR: rd_mux = eye_ctrl; // [R19]
			`OFS_PIN_REGULATOR,
			`OFS_PIN_REGULATOR_SET,
			`OFS_PIN_REGULATOR_CLR: rd_mux = pin_ctrl; // [R19]
			`OFS_DETECTOR_STATUS: rd_mux = {1'b0, det_level}; // [R5]
			// Event in the read cycle appears in the data instead
			`OFS_DETECTOR_LATCH: rd_mux = {1'b0, latch_ff | unmasked}; // [R9]
			default: rd_mux = 8'h00;
		endcase
	end

	// Pad level: push-pull follows SOF, open modes drive one polarity only
	always @* begin
		pump_level = SOF_PULSE_ENABLE & HS_SOF_SEEN;
	end

	always @(posedge CLK) begin
		if (!RST_N) begin
			latch_ff <= {`DET_WIDTH{1'b0}};
			REG_RDATA <= 8'h00;
			REG_RVALID <= 1'b0;
			RX_EVENT <= 1'b0;
			RX_ALT_INT <= 1'b0;
			CHARGE_PUMP_ENABLE_PIN_O <= 1'b0;
			CHARGE_PUMP_ENABLE_PIN_OE <= 1'b1;
			ID_GROUND_DRIVE <= 1'b0;
			USB_REGULATOR_LEVEL_SELECT <= 3'h3;
			HS_DRIVE_STRENGTH <= 4'h1;
			AC_BOOST_ENABLE <= 1'b1;
			HS_OUTPUT_IMPEDANCE <= 2'h0;
			LINE_POLARITY_CONTROL <= 1'b1;
			SOF_PULSE_ENABLE <= 1'b0;
		end else begin
			latch_ff <= nxt_latch;
			REG_RVALID <= REG_RD;
			if (REG_RD)
				REG_RDATA <= rd_mux;
			RX_EVENT <= |unmasked; // [R3] [R11]
			RX_ALT_INT <= unmasked[`DET_BSESS]; // [R10]
			ID_GROUND_DRIVE <= pin_ctrl[`PR_ID_GROUND]; // [R16]
			USB_REGULATOR_LEVEL_SELECT <= pin_ctrl[`PR_VSEL_MSB:0]; // [R17]
			HS_DRIVE_STRENGTH <= eye_ctrl[`EYE_DRIVE_MSB:0];
			AC_BOOST_ENABLE <= eye_ctrl[`EYE_BOOST_BIT]; // [R18]
			HS_OUTPUT_IMPEDANCE <=
				eye_ctrl[`EYE_IMPED_MSB:`EYE_IMPED_LSB];
			LINE_POLARITY_CONTROL <= eye_ctrl[`EYE_POLARITY];
			SOF_PULSE_ENABLE <= pin_ctrl[`PR_SOF_EN] & DEVICE_MODE; // [R12]
			// Open-drain only ever drives the pad low
			CHARGE_PUMP_ENABLE_PIN_O <= pump_level &
				~(pin_ctrl[`PR_DRIVER_MODE] &
				pin_ctrl[`PR_DRAIN_SOURCE]); // [R15]
			if (!pin_ctrl[`PR_DRIVER_MODE])
				CHARGE_PUMP_ENABLE_PIN_OE <= 1'b1; // [R14]
			else if (pin_ctrl[`PR_DRAIN_SOURCE])
				CHARGE_PUMP_ENABLE_PIN_OE <= ~pump_level; // [R15]
			else
				CHARGE_PUMP_ENABLE_PIN_OE <= pump_level; // [R15]
		end
	end
endmodule

//--- link_model.sv
// Link-side model: drives ULPI register writes and reads into the bank.
// Assumes one-cycle strobes, read data one cycle after the read strobe.
`timescale 1ns/1ns
module link_model (
	input wire clk,
	output logic wr = 1'b0,
	output logic rd = 1'b0,
	output logic [7:0] addr = 8'h00,
	output logic [7:0] wdata = 8'h00,
	input wire [7:0] rdata,
	input wire rvalid
);
	// Set only by the debug scenario that drives SOF to the pin
	logic sof_dbg = 1'b0;
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#2;
		wr = 1'b1;
		addr = a;
		wdata = d;
		if (a == 8'h3d || a == 8'h3e)
			wdata[1] = 1'b0;
		if ((a == 8'h85 || a == 8'h86) && !sof_dbg)
			wdata[6] = 1'b0;
		@(posedge clk);
		#2;
		wr = 1'b0;
		addr = ~addr;
		wdata = ~wdata;
	endtask
	task rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#2;
		rd = 1'b1;
		addr = a;
		@(posedge clk);
		#2;
		rd = 1'b0;
		addr = ~addr;
		d = rvalid === 1'b1 ? rdata : 8'hxx;
	endtask
endmodule

//--- vendor_bank_checker.sv
// Port-level assertions for the vendor register bank.
// Assumes the bank's own clock and synchronous active-low reset.
`timescale 1ns/1ns
module vendor_bank_checker (
	input wire CLK,
	input wire RST_N,
	input wire REG_WR,
	input wire REG_RD,
	input wire [7:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_RVALID,
	input wire DEVICE_MODE,
	input wire RX_EVENT,
	input wire RX_ALT_INT,
	input wire CHARGE_PUMP_ENABLE_PIN_O,
	input wire CHARGE_PUMP_ENABLE_PIN_OE,
	input wire ID_GROUND_DRIVE,
	input wire [2:0] USB_REGULATOR_LEVEL_SELECT,
	input wire [3:0] HS_DRIVE_STRENGTH,
	input wire AC_BOOST_ENABLE,
	input wire SOF_PULSE_ENABLE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	a_read_valid: assert property (REG_RD |=> REG_RVALID)
		else $error("read without valid");
	a_boost_drive: assert property (
		AC_BOOST_ENABLE == HS_DRIVE_STRENGTH[0])
		else $error("boost differs from drive bit 0");
	a_sof_device: assert property (SOF_PULSE_ENABLE |-> $past(DEVICE_MODE))
		else $error("SOF output outside device mode");
	a_alt_event: assert property (RX_ALT_INT |-> RX_EVENT)
		else $error("alt flag without event");
	a_pin_drive: assert property (CHARGE_PUMP_ENABLE_PIN_O |->
		CHARGE_PUMP_ENABLE_PIN_OE)
		else $error("pin high while not driven");
	a_level_write: assert property ((REG_WR && REG_ADDR == 8'h85) |->
		##2 USB_REGULATOR_LEVEL_SELECT == $past(REG_WDATA[2:0], 2))
		else $error("regulator level not written");
	a_idgnd_set: assert property ((REG_WR && REG_ADDR == 8'h86 &&
		REG_WDATA[3]) |-> ##2 ID_GROUND_DRIVE)
		else $error("set alias missed");
	a_idgnd_clear: assert property ((REG_WR && REG_ADDR == 8'h87 &&
		REG_WDATA[3]) |-> ##2 !ID_GROUND_DRIVE)
		else $error("clear alias missed");
	c_event: cover property (RX_EVENT);
	c_alt: cover property (RX_ALT_INT);
	c_sof: cover property (SOF_PULSE_ENABLE);
endmodule
bind ulpi_vendor_bank vendor_bank_checker chk (.*);

//--- ulpi_vendor_bank_tb.sv
// Self-checking bench: register model, alias, detector and pin scenarios.
// Assumes the link model drives the register strobes.
`timescale 1ns/1ns
`define CHK(n, e, g) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		err_count++; \
		$display("MISMATCH %s exp %h got %h", n, e, g); \
	end \
end
module ulpi_vendor_bank_tb;
	logic CLK = 0, RST_N = 0, lp = 0, sm = 0, dm = 0, sof = 0;
	logic [6:0] det = 0;
	wire wr, rd, rv, rx, alt, po, poe, idg, bst, pol, sofe;
	wire [7:0] a, wd, q;
	wire [2:0] lvl;
	wire [3:0] drv;
	wire [1:0] imp;
	int err_count = 0, n_checks = 0, i, j, k;
	logic [7:0] m[3], d, w, ba[3] = '{8'h3d, 8'h80, 8'h85};
	logic [7:0] pm[4] = '{8'h40, 8'h60, 8'h50, 8'h70};
	logic [7:0] eb[7] = '{2, 4, 4, 4, 5, 0, 6};
	logic [1:0] pe[4] = '{3, 3, 3, 0};
	ulpi_vendor_bank uut (.CLK(CLK), .RST_N(RST_N), .REG_WR(wr), .REG_RD(rd),
		.REG_ADDR(a), .REG_WDATA(wd), .REG_RDATA(q), .REG_RVALID(rv),
		.LOW_POWER_ENTER(lp), .SERIAL_MODE_ENTER(sm), .DEVICE_MODE(dm),
		.HS_SOF_SEEN(sof), .B_SESSION_DETECTOR_OUT(det[0]),
		.ID_RESISTOR_A_DETECTOR(det[1]), .ID_RESISTOR_B_DETECTOR(det[2]),
		.ID_RESISTOR_C_DETECTOR(det[3]), .ID_OPEN_DETECTOR(det[4]),
		.STRESS_DETECTOR_OUT(det[5]), .SUPPLY_MONITOR_OUT(det[6]),
		.RX_EVENT(rx), .RX_ALT_INT(alt), .CHARGE_PUMP_ENABLE_PIN_O(po),
		.CHARGE_PUMP_ENABLE_PIN_OE(poe), .ID_GROUND_DRIVE(idg),
		.USB_REGULATOR_LEVEL_SELECT(lvl), .HS_DRIVE_STRENGTH(drv),
		.AC_BOOST_ENABLE(bst), .HS_OUTPUT_IMPEDANCE(imp),
		.LINE_POLARITY_CONTROL(pol), .SOF_PULSE_ENABLE(sofe));
	link_model lk (.clk(CLK), .wr(wr), .rd(rd), .addr(a), .wdata(wd),
		.rdata(q), .rvalid(rv));
	initial forever #20 CLK = ~CLK;
	task give_verdict;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk_all;
		for (k = 0; k < 9; k++) begin
			lk.rd_reg(ba[k / 3] + 8'(k % 3), d);
			`CHK("reg", m[k / 3], d)
		end
		`CHK("level", m[2][2:0], lvl)
		`CHK("idgnd", m[2][3], idg)
		`CHK("drive", m[1][3:0], drv)
		`CHK("boost", m[1][0], bst)
		`CHK("imped", m[1][5:4], imp)
		`CHK("polar", m[1][6], pol)
	endtask
	// Waits for one RX command and checks its alt flag
	task ev(input logic e, input logic ae);
		logic s;
		s = 0;
		repeat (12) begin
			@(posedge CLK);
			#2;
			if (rx === 1'b1 && !s) begin
				s = 1;
				`CHK("alt", ae, alt)
			end
		end
		`CHK("event", e, s)
	endtask
	task toggle(input int b);
		@(posedge CLK);
		#2 det[b] = ~det[b];
	endtask
	initial begin
		void'($urandom(11849));
		repeat (12) @(posedge CLK);
		#2 RST_N = 1;
		m = '{8'h00, 8'h41, 8'h03};
		chk_all;
		lk.rd_reg(8'h90, d);
		`CHK("unmapped", 8'h00, d)
		for (i = 0; i < 12; i++) begin
			j = i % 3;
			w = j == 0 ? 8'hfd : j == 2 ? 8'hbf : 8'hff;
			m[j] = $urandom;
			lk.wr_reg(ba[j], m[j]);
			m[j] &= w;
			d = $urandom;
			lk.wr_reg(ba[j] + 8'h01, d);
			m[j] |= d & w;
			d = $urandom;
			lk.wr_reg(ba[j] + 8'h02, d);
			m[j] &= ~d;
			chk_all;
		end
		for (i = 0; i < 7; i++) begin
			for (j = 0; j < 2; j++) begin
				lk.wr_reg(8'h3d, 8'h01 << (i == 0 && j ? 3 : eb[i]));
				toggle(i);
				ev(1, i == 0);
				lk.rd_reg(8'h83, d);
				`CHK("status", {1'b0, det}, d)
				lk.rd_reg(8'h84, d);
				`CHK("latch", 8'h01 << i, d)
				lk.rd_reg(8'h84, d);
				`CHK("latch", 8'h00, d)
			end
		end
		lk.wr_reg(8'h3d, 8'h00);
		@(posedge CLK);
		#2 det = 7'h7f;
		ev(0, 0);
		lk.rd_reg(8'h83, d);
		`CHK("status", 8'h7f, d)
		lk.rd_reg(8'h84, d);
		`CHK("masked", 8'h00, d)
		for (j = 0; j < 2; j++) begin
			lk.wr_reg(8'h3d, 8'h01);
			toggle(5);
			ev(1, 0);
			@(posedge CLK);
			#2 {lp, sm} = j ? 2'b01 : 2'b10;
			@(posedge CLK);
			#2 {lp, sm} = 2'b00;
			lk.rd_reg(8'h84, d);
			`CHK("mode clr", 8'h00, d)
		end
		// Latch read lands in the cycle the stress change is seen
		toggle(5);
		repeat (3) @(posedge CLK);
		lk.rd_reg(8'h84, d);
		`CHK("read event", 8'h20, d)
		lk.rd_reg(8'h84, d);
		`CHK("event dropped", 8'h00, d)
		dm = 1;
		sof = 1;
		lk.sof_dbg = 1;
		for (k = 0; k < 4; k++) begin
			lk.wr_reg(8'h85, pm[k]);
			repeat (3) @(posedge CLK);
			#2;
			`CHK("sof en", 1'b1, sofe)
			`CHK("pin", pe[k], {po, poe})
		end
		sof = 0;
		repeat (3) @(posedge CLK);
		#2;
		`CHK("pin low", 2'h1, {po, poe})
		dm = 0;
		repeat (3) @(posedge CLK);
		#2;
		`CHK("sof en", 1'b0, sofe)
		lk.sof_dbg = 0;
		lk.wr_reg(8'h86, 8'h08);
		repeat (2) @(posedge CLK);
		#2;
		`CHK("idgnd set", 1'b1, idg)
		lk.wr_reg(8'h87, 8'h08);
		repeat (2) @(posedge CLK);
		#2;
		`CHK("idgnd clr", 1'b0, idg)
		give_verdict;
	end
	initial begin
		#(40 * 8000);
		err_count++;
		give_verdict;
	end
endmodule
